// ==== shared/cabx_pkg.sv ====
// shared types and constants of the arithmetic, bit and branch execution slice
`default_nettype none
package cabx_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BIT_W = 3;
  localparam int OFS_W = 9;
  localparam int PC_W = 15;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [7:0] RES_ZERO = 8'h00;
  localparam int JUMP_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;

  // operation requested by decode, one-hot
  typedef enum logic [6:0] {
    CABX_OP_NOP  = 7'h01,
    CABX_OP_ADD  = 7'h02,
    CABX_OP_ADDC = 7'h04,
    CABX_OP_ASR  = 7'h08,
    CABX_OP_BCLR = 7'h10,
    CABX_OP_BTSZ = 7'h20,
    CABX_OP_JREL = 7'h40
  } cabx_op_t;

  // execute state: normal issue or discarding the prefetched word
  typedef enum logic [1:0] {
    CABX_ST_EXEC  = 2'h1,
    CABX_ST_FLUSH = 2'h2
  } cabx_state_t;

  typedef struct packed {
    cabx_op_t op;
    logic [6:0] faddr;
    logic dest;
    logic [2:0] bitsel;
    logic [8:0] offset;
  } cabx_instr_t;

  typedef struct packed {
    logic carry;
    logic nibble_half_overflow;
    logic zero;
  } cabx_flags_t;

  localparam cabx_flags_t FLAGS_RST = '{carry: 1'b0, nibble_half_overflow: 1'b0, zero: 1'b0};
endpackage
`default_nettype wire

// ==== core/cabx_adder.sv ====
// 8-bit adder with carry-in, carry-out and nibble half-carry
`default_nettype none
module cabx_adder #(
  parameter int W = 8,
  parameter int NIB = 4
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  output logic [W-1:0] sum,
  output logic cout,
  output logic half
);
  logic [W:0] full;
  logic [NIB:0] low;

  // carry comes from the top bit; half-carry from the low nibble
  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign low = {1'b0, a[NIB-1:0]} + {1'b0, b[NIB-1:0]} + {{NIB{1'b0}}, cin};
  assign sum = full[W-1:0];
  assign cout = full[W];
  assign half = low[NIB];
endmodule
`default_nettype wire

// ==== core/cabx_exec.sv ====
// execution slice: add, add with carry, arithmetic shift, bit clear, bit skip, relative jump
// Notes on behaviour
// - add accumulator and file register, set C DC Z
// - dest 0 writes accumulator, 1 writes file
// - shift keeps bit 7, bit 0 to carry
// - add accumulator, file and carry, set C DC Z
// - clear chosen bit, flags untouched
// - tested bit zero discards next, two cycles
// - jump to counter plus one plus signed offset
// - relative jump always takes two cycles
`default_nettype none
module cabx_exec #(
  parameter int PCW = cabx_pkg::PC_W,
  parameter int DEPTH = cabx_pkg::FILE_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire cabx_pkg::cabx_instr_t instr,
  input wire logic load_en,
  input wire logic [6:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [6:0] peek_addr,
  output logic [7:0] peek_data,
  output logic [7:0] w_out,
  output cabx_pkg::cabx_flags_t flags_out,
  output logic [PCW-1:0] pc_out,
  output logic flush_out,
  output logic taken_out
);
  logic [7:0] file_mem [DEPTH];
  cabx_pkg::cabx_state_t state_reg;
  logic skip_reg;
  logic take;
  logic [7:0] fval;
  logic [7:0] add_sum;
  logic add_cout;
  logic add_half;
  logic add_cin;
  logic [7:0] asr_val;
  logic [7:0] bclr_val;
  logic bit_is_zero;
  logic [PCW-1:0] ofs_ext;
  logic [PCW-1:0] jump_target;

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch and combinational results

  // the prefetched word is refused while the pipe is being flushed
  assign take = instr_valid && (state_reg == cabx_pkg::CABX_ST_EXEC);
  assign fval = file_mem[instr.faddr];
  // carry-in only for the add-with-carry form
  assign add_cin = (instr.op == cabx_pkg::CABX_OP_ADDC) ? flags_out.carry : 1'b0;
  assign asr_val = {fval[7], fval[7:1]};
  assign bclr_val = fval & ~(8'h01 << instr.bitsel);
  assign bit_is_zero = ~fval[instr.bitsel];
  assign ofs_ext = {{(PCW-cabx_pkg::OFS_W){instr.offset[8]}}, instr.offset};
  assign jump_target = pc_out + {{(PCW-1){1'b0}}, 1'b1} + ofs_ext;

  cabx_adder #(
    .W(cabx_pkg::DATA_W),
    .NIB(cabx_pkg::NIB_W)
  ) u_adder (
    .a(w_out),
    .b(fval),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .half(add_half)
  );

  ////////////////////////////////////////////////////////////////////////////
  // file registers: no reset, this is plain storage

  // an executed write wins over a preload to the same cycle
  always_ff @(posedge clk) begin
    if (take && instr.dest && (instr.op inside {cabx_pkg::CABX_OP_ADD,
        cabx_pkg::CABX_OP_ADDC})) begin
      file_mem[instr.faddr] <= add_sum;
    end else if (take && instr.dest && instr.op == cabx_pkg::CABX_OP_ASR) begin
      file_mem[instr.faddr] <= asr_val;
    end else if (take && instr.op == cabx_pkg::CABX_OP_BCLR) begin
      file_mem[instr.faddr] <= bclr_val;
    end else if (load_en) begin
      file_mem[load_addr] <= load_data;
    end
  end

  // registered readback port for whoever needs to observe the file
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      peek_data <= cabx_pkg::RES_ZERO;
    end else begin
      peek_data <= file_mem[peek_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_out <= cabx_pkg::W_RST;
    end else if (take && !instr.dest) begin
      if (instr.op inside {cabx_pkg::CABX_OP_ADD, cabx_pkg::CABX_OP_ADDC}) begin
        w_out <= add_sum;
      end else if (instr.op == cabx_pkg::CABX_OP_ASR) begin
        w_out <= asr_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // shift touches only carry and zero; bit ops and jumps touch nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_out <= cabx_pkg::FLAGS_RST;
    end else if (take) begin
      unique case (instr.op)
        cabx_pkg::CABX_OP_ADD, cabx_pkg::CABX_OP_ADDC: begin
          flags_out.carry <= add_cout;
          flags_out.nibble_half_overflow <= add_half;
          flags_out.zero <= (add_sum == cabx_pkg::RES_ZERO);
        end
        cabx_pkg::CABX_OP_ASR: begin
          flags_out.carry <= fval[0];
          flags_out.zero <= (asr_val == cabx_pkg::RES_ZERO);
        end
        default: begin
          flags_out <= flags_out;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, issue state and flush

  // during flush the counter steps over a skipped word but not a jump target
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_out <= cabx_pkg::PC_RST[PCW-1:0];
    end else if (take && instr.op == cabx_pkg::CABX_OP_JREL) begin
      pc_out <= jump_target;
    end else if (take || (state_reg == cabx_pkg::CABX_ST_FLUSH && skip_reg)) begin
      pc_out <= pc_out + {{(PCW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= cabx_pkg::CABX_ST_EXEC;
      flush_out <= 1'b0;
      skip_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        cabx_pkg::CABX_ST_EXEC: begin
          if (take && (instr.op == cabx_pkg::CABX_OP_JREL ||
              (instr.op == cabx_pkg::CABX_OP_BTSZ && bit_is_zero))) begin
            state_reg <= cabx_pkg::CABX_ST_FLUSH;
            flush_out <= 1'b1;
            skip_reg <= (instr.op == cabx_pkg::CABX_OP_BTSZ);
          end
        end
        cabx_pkg::CABX_ST_FLUSH: begin
          // one dead cycle is the second instruction cycle
          state_reg <= cabx_pkg::CABX_ST_EXEC;
          flush_out <= 1'b0;
          skip_reg <= 1'b0;
        end
        default: begin
          state_reg <= cabx_pkg::CABX_ST_EXEC;
          flush_out <= 1'b0;
          skip_reg <= 1'b0;
        end
      endcase
    end
  end

  // one-cycle pulse: this edge accepted an instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      taken_out <= 1'b0;
    end else begin
      taken_out <= take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  add_result_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_ADD && !instr.dest
    |=> w_out == 8'($past(w_out) + $past(fval)))
    else $error("add result wrong");
  dest_file_a: assert property (
    take && instr.dest && instr.op != cabx_pkg::CABX_OP_NOP |=> $stable(w_out))
    else $error("accumulator changed on file destination");
  shift_value_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_ASR && !instr.dest
    |=> w_out == {$past(fval[7]), $past(fval[7:1])} && flags_out.carry == $past(fval[0])
        && $stable(flags_out.nibble_half_overflow))
    else $error("arithmetic shift wrong");
  addc_sum_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_ADDC && !instr.dest
    |=> w_out == 8'($past(w_out) + $past(fval) + {7'h00, $past(flags_out.carry)}))
    else $error("add with carry wrong");
  bitclr_flags_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_BCLR |=> $stable(flags_out) && $stable(w_out))
    else $error("bit clear touched state");
  skip_taken_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_BTSZ && bit_is_zero
    |=> flush_out && taken_out ##1 !flush_out && !taken_out)
    else $error("skip did not take two cycles");
  skip_not_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_BTSZ && !bit_is_zero
    |=> !flush_out && pc_out == $past(pc_out) + 1'b1)
    else $error("skip happened on set bit");
  jump_target_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_JREL
    |=> pc_out == PCW'($past(pc_out) + 1'b1 + $past(ofs_ext)) ##1 $stable(pc_out))
    else $error("jump target wrong");
  jump_cycles_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_JREL |=> flush_out ##1 !flush_out)
    else $error("jump not two cycles");
  add_carry_a: assert property (
    take && instr.op == cabx_pkg::CABX_OP_ADD
    |=> flags_out.carry == (({1'b0, $past(w_out)} + {1'b0, $past(fval)}) > 9'h0FF))
    else $error("carry not from bit seven");

  add_file_c: cover property (take && instr.op == cabx_pkg::CABX_OP_ADD && instr.dest);
  skip_taken_c: cover property (take && instr.op == cabx_pkg::CABX_OP_BTSZ && bit_is_zero);
  jump_back_c: cover property (take && instr.op == cabx_pkg::CABX_OP_JREL && instr.offset[8]);
  addc_carry_c: cover property (take && instr.op == cabx_pkg::CABX_OP_ADDC && flags_out.carry);
endmodule
`default_nettype wire

// ==== tb/tb_core_arith_bit_branch_exec.sv ====
// self-checking bench for the arithmetic, bit and branch execution slice
`default_nettype none
module tb_core_arith_bit_branch_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  cabx_pkg::cabx_instr_t instr;
  logic load_en = 1'b0;
  logic [6:0] load_addr = 7'h00;
  logic [7:0] load_data = 8'h00;
  logic [6:0] peek_addr = 7'h00;
  logic [7:0] peek_data;
  logic [7:0] w_out;
  cabx_pkg::cabx_flags_t flags_out;
  logic [14:0] pc_out;
  logic flush_out;
  logic taken_out;
  // bench copy of the architectural state: file, accumulator, {carry, half, zero}, counter
  logic [7:0] fm [128];
  logic [7:0] m_w;
  logic [2:0] m_fl;
  logic [14:0] m_pc;
  logic [31:0] rs = 32'h0000_0035;
  int n_fail = 0;
  int checks_done = 0;
  cabx_pkg::cabx_op_t ops [6] = '{cabx_pkg::CABX_OP_ADD, cabx_pkg::CABX_OP_ADDC,
    cabx_pkg::CABX_OP_ASR, cabx_pkg::CABX_OP_BCLR, cabx_pkg::CABX_OP_BTSZ,
    cabx_pkg::CABX_OP_JREL};

  always #2 clk = ~clk;

  cabx_exec dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .peek_addr(peek_addr), .peek_data(peek_data), .w_out(w_out),
    .flags_out(flags_out), .pc_out(pc_out), .flush_out(flush_out), .taken_out(taken_out));

  ////////////////////////////////////////////////////////////////////////////////
  // xorshift source, fixed start so every run replays the same stream
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] add3(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {s[8], h[4], s[7:0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one compare per kind of result; all of them feed the same two counters
  task automatic chk_acc(input string what, input logic [7:0] exp, input logic [7:0] got);
    chk(what, {8'h00, exp}, {8'h00, got});
  endtask

  task automatic chk_fl(input string what, input logic [2:0] exp, input logic [2:0] got);
    chk(what, {13'h0000, exp}, {13'h0000, got});
  endtask

  task automatic chk_pc(input string what, input logic [14:0] exp, input logic [14:0] got);
    chk(what, {1'b0, exp}, {1'b0, got});
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one instruction, then either the dead cycle with a refused offer or an idle cycle
  task automatic issue(input cabx_pkg::cabx_op_t op, input logic [6:0] fa, input logic d,
                       input logic [2:0] b, input logic [8:0] ofs);
    logic [9:0] r;
    logic [7:0] f;
    logic skip;
    f = fm[fa];
    skip = 1'b0;
    r = 10'h000;
    m_pc = m_pc + 15'h0001;
    case (op)
      cabx_pkg::CABX_OP_ADD: r = add3(m_w, f, 1'b0);
      cabx_pkg::CABX_OP_ADDC: r = add3(m_w, f, m_fl[2]);
      cabx_pkg::CABX_OP_ASR: r = {f[0], m_fl[1], f[7], f[7:1]};
      cabx_pkg::CABX_OP_BCLR: fm[fa][b] = 1'b0;
      cabx_pkg::CABX_OP_BTSZ: skip = ~f[b];
      cabx_pkg::CABX_OP_JREL: begin
        m_pc = m_pc + {{6{ofs[8]}}, ofs};
        skip = 1'b1;
      end
      default: r = 10'h000;
    endcase
    if (op inside {cabx_pkg::CABX_OP_ADD, cabx_pkg::CABX_OP_ADDC, cabx_pkg::CABX_OP_ASR}) begin
      m_fl = {r[9], r[8], r[7:0] == 8'h00};
      if (d) begin
        fm[fa] = r[7:0];
      end else begin
        m_w = r[7:0];
      end
    end
    instr = '{op: op, faddr: fa, dest: d, bitsel: b, offset: ofs};
    instr_valid = 1'b1;
    peek_addr = fa;
    @(posedge clk);
    @(negedge clk);
    chk_bit("taken", 1'b1, taken_out);
    chk_acc("acc", m_w, w_out);
    chk_fl("flags", m_fl, flags_out);
    chk_pc("pc", m_pc, pc_out);
    chk_bit("flush", skip, flush_out);
    // an add offered in the dead cycle must vanish without trace
    instr_valid = skip;
    instr.op = cabx_pkg::CABX_OP_ADD;
    instr.dest = 1'b0;
    @(posedge clk);
    @(negedge clk);
    instr_valid = 1'b0;
    if (op == cabx_pkg::CABX_OP_BTSZ && skip) begin
      m_pc = m_pc + 15'h0001;
    end
    chk_bit("taken2", 1'b0, taken_out);
    chk_bit("flush2", 1'b0, flush_out);
    chk_acc("acc2", m_w, w_out);
    chk_pc("pc2", m_pc, pc_out);
    chk_acc("file", fm[fa], peek_data);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset, preload, corner cases, then a random stream
  initial begin
    logic [31:0] v;
    instr = '{op: cabx_pkg::CABX_OP_NOP, default: '0};
    m_w = cabx_pkg::W_RST;
    m_fl = 3'h0;
    m_pc = cabx_pkg::PC_RST;
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    chk_pc("rst_pc", cabx_pkg::PC_RST, pc_out);
    chk_acc("rst_acc", cabx_pkg::W_RST, w_out);
    for (int i = 0; i < 128; i++) begin
      v = xs();
      fm[i] = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : (i == 2) ? 8'h81 : v[7:0];
      load_en = 1'b1;
      load_addr = 7'(i);
      load_data = fm[i];
      @(negedge clk);
    end
    load_en = 1'b0;
    issue(cabx_pkg::CABX_OP_ADD, 7'h00, 1'b0, 3'h0, 9'h000);
    issue(cabx_pkg::CABX_OP_ADD, 7'h01, 1'b0, 3'h0, 9'h000);
    issue(cabx_pkg::CABX_OP_ADDC, 7'h01, 1'b1, 3'h0, 9'h000);
    issue(cabx_pkg::CABX_OP_ASR, 7'h02, 1'b1, 3'h0, 9'h000);
    issue(cabx_pkg::CABX_OP_ASR, 7'h02, 1'b0, 3'h0, 9'h000);
    for (int b = 0; b < 8; b++) begin
      issue(cabx_pkg::CABX_OP_BCLR, 7'h7F, 1'b1, 3'(b), 9'h000);
    end
    issue(cabx_pkg::CABX_OP_BTSZ, 7'h7F, 1'b0, 3'h7, 9'h000);
    issue(cabx_pkg::CABX_OP_BTSZ, 7'h00, 1'b0, 3'h7, 9'h000);
    issue(cabx_pkg::CABX_OP_JREL, 7'h00, 1'b0, 3'h0, 9'h100);
    issue(cabx_pkg::CABX_OP_JREL, 7'h00, 1'b0, 3'h0, 9'h0FF);
    // a no-operation with the file target set must leave file and accumulator alone
    issue(cabx_pkg::CABX_OP_NOP, 7'h03, 1'b1, 3'h0, 9'h000);
    repeat (400) begin
      v = xs();
      issue(ops[v % 32'd6], v[9:3], v[10], v[13:11], v[22:14]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
